// file: src/dsparith_pkg.sv
/*
 * Shared constants and types of the fixed-point arithmetic datapath: widths, reset values,
 * product shift encodings, saturation limits, operation codes and controller states.
 * Assumes nothing of its surroundings; it is compiled before the design modules.
 */
package dsparith_pkg;

   localparam int          DATA_W    = 16;
   localparam int          ACC_W     = 32;
   localparam int          IMM_W     = 13;
   localparam int          SHAMT_W   = 5;
   localparam int          INDEX_W   = 4;
   localparam logic [4:0]  SHIFT_MAX = 5'h10;

   // Product shift select encodings.
   localparam logic [1:0]  PSHIFT_NONE  = 2'h0;
   localparam logic [1:0]  PSHIFT_LEFT1 = 2'h1;
   localparam logic [1:0]  PSHIFT_LEFT4 = 2'h2;
   localparam logic [1:0]  PSHIFT_RIGHT6 = 2'h3;

   // Mode reset values.
   localparam logic [1:0]  PSHIFT_RESET   = 2'h0;
   localparam logic        SIGNEXT_RESET  = 1'h1;
   localparam logic        SATURATE_RESET = 1'h0;

   // Accumulator values loaded on a saturated overflow.
   localparam logic [31:0] SAT_POSITIVE = 32'h07ffffff;
   localparam logic [31:0] SAT_NEGATIVE = 32'h08000000;

   typedef enum logic [4:0] {
      OP_NOP                    = 5'h00,
      OP_LOAD_ACC               = 5'h01,
      OP_ADD_ACC                = 5'h02,
      OP_SUB_ACC                = 5'h03,
      OP_AND_ACC                = 5'h04,
      OP_OR_ACC                 = 5'h05,
      OP_XOR_ACC                = 5'h06,
      OP_LOAD_ACC_REG_SHIFT     = 5'h07,
      OP_ADD_ACC_REG_SHIFT      = 5'h08,
      OP_SUB_ACC_REG_SHIFT      = 5'h09,
      OP_LOAD_OPERAND           = 5'h0a,
      OP_LOAD_OPERAND_MOVE_PROD = 5'h0b,
      OP_LOAD_OPERAND_ADD_PROD  = 5'h0c,
      OP_LOAD_OPERAND_SUB_PROD  = 5'h0d,
      OP_LOAD_OPERAND_ADD_MOVE  = 5'h0e,
      OP_SIGNED_MULTIPLY        = 5'h0f,
      OP_SIGNED_MULTIPLY_IMM    = 5'h10,
      OP_UNSIGNED_MULTIPLY      = 5'h11,
      OP_MULTIPLY_ACCUMULATE    = 5'h12,
      OP_MULTIPLY_ACC_MOVE      = 5'h13,
      OP_SQUARE_ADD             = 5'h14,
      OP_SQUARE_SUBTRACT        = 5'h15,
      OP_STORE_PRODUCT_HIGH     = 5'h16,
      OP_STORE_PRODUCT_LOW      = 5'h17,
      OP_LOAD_PRODUCT_HIGH      = 5'h18,
      OP_BIT_TEST_INDEXED       = 5'h19,
      OP_NORMALISE_ACC          = 5'h1a,
      OP_BRANCH_TO_ACC          = 5'h1b,
      OP_ADD_PRODUCT            = 5'h1c
   } dsparith_op_type;

   typedef enum logic [2:0] {
      ALU_NONE = 3'h0,
      ALU_LOAD = 3'h1,
      ALU_ADD  = 3'h2,
      ALU_SUB  = 3'h3,
      ALU_AND  = 3'h4,
      ALU_OR   = 3'h5,
      ALU_XOR  = 3'h6
   } dsparith_alu_type;

   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,
      ST_IMM_WAIT = 2'b01
   } dsparith_state_type;

endpackage

// file: src/dsparith_mult.sv
/*
 * Registered 16x16 multiplier holding the 32-bit product register, with a direct load of the
 * product's upper half. Assumes operands are stable in the cycle multGo is high.
 */
`timescale 1ns/1ps
`default_nettype none

module dsparith_mult #(
   parameter int OPW = 16
) (
   input  wire logic             clock,
   input  wire logic             srst,
   input  wire logic             multGo,
   input  wire logic             unsignedMode,
   input  wire logic [OPW-1:0]   opA,
   input  wire logic [OPW-1:0]   opB,
   input  wire logic             loadHigh,
   input  wire logic [OPW-1:0]   highWord,
   output var  logic [2*OPW-1:0] productReg
);

   // One extra bit per operand lets a single signed multiplier serve both signednesses.
   logic signed [OPW:0]     extA;
   logic signed [OPW:0]     extB;
   logic signed [2*OPW+1:0] fullProduct;
   logic        [2*OPW-1:0] product_next;

   assign extA        = {~unsignedMode & opA[OPW-1], opA};
   assign extB        = {~unsignedMode & opB[OPW-1], opB};
   assign fullProduct = extA * extB;
   assign product_next = multGo   ? fullProduct[2*OPW-1:0] :
                         loadHigh ? {highWord, productReg[OPW-1:0]} : productReg;

   always_ff @(posedge clock) begin
      if (srst) begin
         productReg <= '0;
      end else begin
         productReg <= product_next;
      end
   end

endmodule // dsparith_mult

`default_nettype wire

// file: src/dsparith_datapath.sv
/*
 * Fixed-point arithmetic datapath: input scaling shifter, multiplier with operand and product
 * registers, product shifter, central ALU with accumulator, saturation, normalise and bit test.
 * Assumes operations, bus words and mode controls come from sequencing logic on the same clock,
 * and that address generation for coefficients and samples lives outside this block.
 */
`timescale 1ns/1ps
`default_nettype none

module dsparith_datapath
#(
   parameter int DW = dsparith_pkg::DATA_W
) (
   input  wire logic                                clock,
   input  wire logic                                srst,
   input  wire logic                                opValid,
   input  wire dsparith_pkg::dsparith_op_type        opCode,
   input  wire logic [dsparith_pkg::SHAMT_W-1:0]    shiftConst,
   input  wire logic [DW-1:0]                       dataReadBus,
   input  wire logic [DW-1:0]                       programReadBus,
   input  wire logic [dsparith_pkg::IMM_W-1:0]      immOperand,
   input  wire logic                                statusLoad,
   input  wire logic [1:0]                          statusProductShiftSel,
   input  wire logic                                statusSignExtendMode,
   input  wire logic                                statusSaturateMode,
   input  wire logic                                statusOverflowFlag,
   input  wire logic                                overflowBranchTaken,
   output var  logic                                ready,
   output var  logic [dsparith_pkg::ACC_W-1:0]      accumulator,
   output var  logic [DW-1:0]                       multOperand,
   output var  logic [dsparith_pkg::ACC_W-1:0]      productValue,
   output var  logic [DW-1:0]                       dataWriteBus,
   output var  logic                                dataWriteValid,
   output var  logic                                moveNextValid,
   output var  logic                                testFlag,
   output var  logic                                overflowFlag,
   output var  logic                                accZero,
   output var  logic [DW-1:0]                       branchTarget,
   output var  logic                                branchValid,
   output var  logic [1:0]                          productShiftSel,
   output var  logic                                signExtendMode,
   output var  logic                                saturateMode
);

   import dsparith_pkg::*;

   function automatic logic [31:0] scaleInput(input logic [15:0] d, input logic [4:0] amt,
                                              input logic sx);
      logic [31:0] ext;
      ext = {{16{sx & d[15]}}, d};
      return ext << amt;
   endfunction

   function automatic logic [31:0] scaleProduct(input logic [31:0] p, input logic [1:0] sel);
      logic [31:0] r;
      r = p;
      case (sel)
         PSHIFT_NONE:   r = p;
         PSHIFT_LEFT1:  r = {p[30:0], 1'h0};
         PSHIFT_LEFT4:  r = {p[27:0], 4'h0};
         PSHIFT_RIGHT6: r = {{6{p[31]}}, p[31:6]};
         default:       r = p;
      endcase
      return r;
   endfunction

   function automatic dsparith_alu_type aluOf(input dsparith_op_type op);
      dsparith_alu_type k;
      k = ALU_NONE;
      case (op)
         OP_LOAD_ACC, OP_LOAD_ACC_REG_SHIFT, OP_LOAD_OPERAND_MOVE_PROD: k = ALU_LOAD;
         OP_ADD_ACC, OP_ADD_ACC_REG_SHIFT, OP_LOAD_OPERAND_ADD_PROD, OP_LOAD_OPERAND_ADD_MOVE,
         OP_MULTIPLY_ACCUMULATE, OP_MULTIPLY_ACC_MOVE, OP_SQUARE_ADD, OP_ADD_PRODUCT: k = ALU_ADD;
         OP_SUB_ACC, OP_SUB_ACC_REG_SHIFT, OP_LOAD_OPERAND_SUB_PROD, OP_SQUARE_SUBTRACT:
            k = ALU_SUB;
         OP_AND_ACC: k = ALU_AND;
         OP_OR_ACC:  k = ALU_OR;
         OP_XOR_ACC: k = ALU_XOR;
         default:    k = ALU_NONE;
      endcase
      return k;
   endfunction

   dsparith_state_type state_reg;
   dsparith_state_type state_next;
   logic [31:0]        acc_reg;
   logic [31:0]        acc_next;
   logic [15:0]        operand_reg;
   logic [15:0]        operand_next;
   logic [IMM_W-1:0]   immHold_reg;
   logic [31:0]        productReg;
   logic [1:0]         pshift_reg;
   logic               signExt_reg;
   logic               saturate_reg;
   logic               ovFlag_reg;
   logic               ovFlag_next;

   logic               accepted;
   dsparith_alu_type   aluKind;
   logic               isRegShift;
   logic               usesProduct;
   logic               loadsOperand;
   logic               isMacFamily;
   logic               isSquare;
   logic [4:0]         shiftAmt;
   logic [31:0]        inScaled;
   logic [31:0]        prodScaled;
   logic [31:0]        aluB;
   logic [31:0]        sumValue;
   logic [31:0]        diffValue;
   logic               ovAdd;
   logic               ovSub;
   logic               arithOverflow;
   logic [31:0]        aluRaw;
   logic [31:0]        aluResult;
   logic               normShift;
   logic               multGo;
   logic               multUnsigned;
   logic [15:0]        multA;
   logic [15:0]        multB;
   logic [15:0]        immExtended;
   logic               storeHigh;
   logic               storeLow;
   logic               loadProductHigh;

   // Operations offered while an immediate multiply completes are not taken.
   assign accepted     = opValid && (state_reg == ST_IDLE);
   assign aluKind      = accepted ? aluOf(opCode) : ALU_NONE;
   assign isRegShift   = (opCode == OP_LOAD_ACC_REG_SHIFT) || (opCode == OP_ADD_ACC_REG_SHIFT) ||
                         (opCode == OP_SUB_ACC_REG_SHIFT);
   assign loadsOperand = (opCode == OP_LOAD_OPERAND) || (opCode == OP_LOAD_OPERAND_MOVE_PROD) ||
                         (opCode == OP_LOAD_OPERAND_ADD_PROD) ||
                         (opCode == OP_LOAD_OPERAND_SUB_PROD) ||
                         (opCode == OP_LOAD_OPERAND_ADD_MOVE);
   assign isMacFamily  = (opCode == OP_MULTIPLY_ACCUMULATE) || (opCode == OP_MULTIPLY_ACC_MOVE);
   assign isSquare     = (opCode == OP_SQUARE_ADD) || (opCode == OP_SQUARE_SUBTRACT);
   assign usesProduct  = (loadsOperand && (opCode != OP_LOAD_OPERAND)) || isMacFamily ||
                         isSquare || (opCode == OP_ADD_PRODUCT);

   // Shift counts above 16 are clamped so a stray constant cannot push data off the top.
   assign shiftAmt   = isRegShift ? {1'h0, operand_reg[INDEX_W-1:0]} :
                       (shiftConst > SHIFT_MAX) ? SHIFT_MAX : shiftConst;
   assign inScaled   = scaleInput(dataReadBus, shiftAmt, signExt_reg);
   assign prodScaled = scaleProduct(productReg, pshift_reg);
   assign aluB       = usesProduct ? prodScaled : inScaled;

   assign sumValue  = acc_reg + aluB;
   assign diffValue = acc_reg - aluB;
   assign ovAdd     = (acc_reg[31] == aluB[31]) && (sumValue[31] != acc_reg[31]);
   assign ovSub     = (acc_reg[31] != aluB[31]) && (diffValue[31] != acc_reg[31]);
   assign arithOverflow = ((aluKind == ALU_ADD) && ovAdd) ||
                          ((aluKind == ALU_SUB) && ovSub);

   assign aluRaw = (aluKind == ALU_LOAD) ? aluB :
                   (aluKind == ALU_ADD)  ? sumValue :
                   (aluKind == ALU_SUB)  ? diffValue :
                   (aluKind == ALU_AND)  ? (acc_reg & aluB) :
                   (aluKind == ALU_OR)   ? (acc_reg | aluB) :
                   (aluKind == ALU_XOR)  ? (acc_reg ^ aluB) : acc_reg;
   // An overflowed sum always has the sign opposite to the accumulator it started from.
   assign aluResult = (arithOverflow && saturate_reg) ?
                      (acc_reg[31] ? SAT_NEGATIVE : SAT_POSITIVE) : aluRaw;

   // Normalise shifts only while the two top bits agree, so a normalised value stays put.
   assign normShift = accepted && (opCode == OP_NORMALISE_ACC) &&
                      (acc_reg[31] == acc_reg[30]) && (acc_reg != '0);
   assign acc_next  = normShift ? {acc_reg[30:0], 1'h0} : aluResult;

   // The immediate is held so the second multiply cycle does not depend on the request inputs.
   assign immExtended  = {{(16 - IMM_W){immHold_reg[IMM_W-1]}}, immHold_reg[IMM_W-1:0]};
   assign multGo       = (accepted && ((opCode == OP_SIGNED_MULTIPLY) ||
                          (opCode == OP_UNSIGNED_MULTIPLY) || isMacFamily || isSquare)) ||
                         (state_reg == ST_IMM_WAIT);
   assign multUnsigned = accepted && (opCode == OP_UNSIGNED_MULTIPLY);
   assign multA        = (accepted && (isMacFamily || isSquare)) ? dataReadBus : operand_reg;
   assign multB        = (state_reg == ST_IMM_WAIT) ? immExtended :
                         (accepted && isMacFamily) ? programReadBus :
                         dataReadBus;

   assign operand_next = (accepted && (loadsOperand || isMacFamily || isSquare)) ?
                         dataReadBus : operand_reg;

   // The dead cycle after an immediate multiply is the cycle in which its product is formed.
   assign state_next = (accepted && (opCode == OP_SIGNED_MULTIPLY_IMM)) ? ST_IMM_WAIT :
                       ST_IDLE;

   assign storeHigh = accepted && (opCode == OP_STORE_PRODUCT_HIGH);
   assign storeLow  = accepted && (opCode == OP_STORE_PRODUCT_LOW);
   assign loadProductHigh = accepted && (opCode == OP_LOAD_PRODUCT_HIGH);

   // Hardware-set overflow wins over a clear arriving in the same cycle.
   assign ovFlag_next = arithOverflow ? 1'h1 :
                        statusLoad ? statusOverflowFlag :
                        overflowBranchTaken ? 1'h0 : ovFlag_reg;

   dsparith_mult #(
      .OPW (DW)
   ) multUnit (
      .clock        (clock),
      .srst         (srst),
      .multGo       (multGo),
      .unsignedMode (multUnsigned),
      .opA          (multA),
      .opB          (multB),
      .loadHigh     (loadProductHigh),
      .highWord     (dataReadBus),
      .productReg   (productReg)
   );

   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg    <= ST_IDLE;
         acc_reg      <= '0;
         operand_reg  <= '0;
         immHold_reg  <= '0;
         pshift_reg   <= PSHIFT_RESET;
         signExt_reg  <= SIGNEXT_RESET;
         saturate_reg <= SATURATE_RESET;
         ovFlag_reg   <= 1'h0;
      end else begin
         state_reg    <= state_next;
         acc_reg      <= acc_next;
         operand_reg  <= operand_next;
         if (accepted && (opCode == OP_SIGNED_MULTIPLY_IMM)) begin
            immHold_reg <= immOperand;
         end
         if (statusLoad) begin
            pshift_reg   <= statusProductShiftSel;
            signExt_reg  <= statusSignExtendMode;
            saturate_reg <= statusSaturateMode;
         end
         ovFlag_reg   <= ovFlag_next;
      end
   end

   // Store, branch and flag outputs are registered, so each port comes straight from a flip-flop.
   always_ff @(posedge clock) begin
      if (srst) begin
         ready          <= 1'h0;
         dataWriteBus   <= '0;
         dataWriteValid <= 1'h0;
         moveNextValid  <= 1'h0;
         testFlag       <= 1'h0;
         branchTarget   <= '0;
         branchValid    <= 1'h0;
         accZero        <= 1'h1;
      end else begin
         ready          <= (state_next == ST_IDLE);
         dataWriteBus   <= storeHigh ? prodScaled[31:16] : prodScaled[15:0];
         dataWriteValid <= storeHigh || storeLow;
         moveNextValid  <= accepted && ((opCode == OP_LOAD_OPERAND_ADD_MOVE) ||
                           (opCode == OP_MULTIPLY_ACC_MOVE));
         if (accepted && (opCode == OP_BIT_TEST_INDEXED)) begin
            testFlag <= dataReadBus[~operand_reg[INDEX_W-1:0]];
         end else if (accepted && (opCode == OP_NORMALISE_ACC)) begin
            testFlag <= acc_reg[31] ^ acc_reg[30];
         end
         branchTarget   <= acc_reg[15:0];
         branchValid    <= accepted && (opCode == OP_BRANCH_TO_ACC);
         accZero        <= (acc_next == '0);
      end
   end

   // Mode copies let the sequencing logic see the current scaling without a separate path.
   assign accumulator     = acc_reg;
   assign multOperand     = operand_reg;
   assign productValue    = productReg;
   assign overflowFlag    = ovFlag_reg;
   assign productShiftSel = pshift_reg;
   assign signExtendMode  = signExt_reg;
   assign saturateMode    = saturate_reg;

endmodule // dsparith_datapath

`default_nettype wire

// file: bench/dsparith_ref.svh
/* Bench-side reference helpers: sign extension and both scaling shifters.
   Assumes inclusion inside a module that imports dsparith_pkg. */
function automatic logic [31:0] sx(input logic [15:0] v);
   sx = {{16{v[15]}}, v};
endfunction
function automatic logic [31:0] ish(input logic [15:0] v, input logic [4:0] n, input logic s);
   ish = (s ? sx(v) : {16'h0, v}) << n;
endfunction
function automatic logic [31:0] psh(input logic [31:0] p, input logic [1:0] m);
   case (m)
      PSHIFT_LEFT1: psh = p << 1;
      PSHIFT_LEFT4: psh = p << 4;
      PSHIFT_RIGHT6: psh = {{6{p[31]}}, p[31:6]};
      default: psh = p;
   endcase
endfunction

// file: bench/dsparith_mem_model.sv
/* Data and program memory read buses feeding the datapath.
   Assumes the bench fills both tables and drives the read strobe and addresses. */
`timescale 1ns/1ps
`default_nettype none
module dsparith_mem_model (
   input  wire logic        clock,
   input  wire logic        readEn,
   input  wire logic [3:0]  dataAddr,
   input  wire logic [3:0]  coefAddr,
   input  wire logic        moveNext,
   output logic      [15:0] dataWord,
   output logic      [15:0] coefWord
);
   logic [15:0] dataMem [16];
   logic [15:0] coefMem [16];
   logic [15:0] lastData = 16'h0;
   logic [15:0] lastCoef = 16'h0;
   logic [3:0]  lastAddr = 4'h0;
   // Idle buses show the inverse of the last word, so a stale sample never looks valid.
   assign dataWord = readEn ? dataMem[dataAddr] : ~lastData;
   assign coefWord = readEn ? coefMem[coefAddr] : ~lastCoef;
   always @(posedge clock) begin
      if (readEn) begin
         lastData <= dataWord;
         lastCoef <= coefWord;
         lastAddr <= dataAddr;
      end
      if (moveNext) dataMem[lastAddr + 4'h1] <= dataMem[lastAddr];
   end
endmodule // dsparith_mem_model
`default_nettype wire

// file: bench/dsparith_checker.sv
/* Port assertions for the arithmetic datapath.
   Assumes binding onto dsparith_datapath with its default data width. */
`timescale 1ns/1ps
`default_nettype none
module dsparith_checker
   import dsparith_pkg::*;
(
   input wire logic            clock,
   input wire logic            srst,
   input wire logic            opValid,
   input wire dsparith_op_type opCode,
   input wire logic            ready,
   input wire logic [31:0]     accumulator,
   input wire logic [31:0]     productValue,
   input wire logic [15:0]     multOperand,
   input wire logic [15:0]     dataReadBus,
   input wire logic [15:0]     dataWriteBus,
   input wire logic            dataWriteValid,
   input wire logic            overflowFlag,
   input wire logic            accZero,
   input wire logic [15:0]     branchTarget,
   input wire logic            branchValid,
   input wire logic            saturateMode,
   input wire logic            statusLoad,
   input wire logic            overflowBranchTaken,
   input wire logic [1:0]      productShiftSel,
   input wire logic            signExtendMode
);
`include "dsparith_ref.svh"
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   wire logic take;
   assign take = opValid && ready;
   rst_vals_a:
      assert property ($fell(srst) |-> productShiftSel == PSHIFT_RESET && signExtendMode
         && accumulator == 32'h0 && accZero) else $error("reset values wrong");
   imm_ready_a:
      assert property (take && opCode == OP_SIGNED_MULTIPLY_IMM |=> !ready ##1 ready)
         else $error("immediate multiply spacing wrong");
   store_high_a:
      assert property (take && opCode == OP_STORE_PRODUCT_HIGH |=> dataWriteValid
         && dataWriteBus == 16'(psh($past(productValue), $past(productShiftSel)) >> 16))
         else $error("product high store wrong");
   acc_zero_a:
      assert property (accZero == (accumulator == 32'h0)) else $error("zero flag wrong");
   ovf_sticky_a:
      assert property (overflowFlag && !overflowBranchTaken && !statusLoad |=> overflowFlag)
         else $error("overflow flag dropped");
   branch_acc_a:
      assert property (take && opCode == OP_BRANCH_TO_ACC |=> branchValid
         && branchTarget == 16'($past(accumulator))) else $error("branch target wrong");
   bit_test_a:
      assert property (take && opCode == OP_BIT_TEST_INDEXED |=> $stable(accumulator))
         else $error("bit test changed accumulator");
   mult_signed_a:
      assert property (take && opCode == OP_SIGNED_MULTIPLY |=> productValue ==
         sx($past(multOperand)) * sx($past(dataReadBus))) else $error("product wrong");
   sat_limit_a:
      assert property ($rose(overflowFlag) && saturateMode && !$past(statusLoad) |->
         accumulator == SAT_POSITIVE || accumulator == SAT_NEGATIVE)
         else $error("saturation value wrong");
endmodule // dsparith_checker
`default_nettype wire

// file: bench/dsparith_datapath_bench.sv
/* Self-checking bench: a reference model notes expected outputs, a watcher compares them.
   Assumes the memory model, the checker and the shared reference helpers. */
`timescale 1ns/1ps
`default_nettype none
module dsparith_datapath_bench;
   import dsparith_pkg::*;
`include "dsparith_ref.svh"
   logic clock, srst = 1'b1, opValid = 1'b0, statusLoad = 1'b0, overflowBranchTaken = 1'b0;
   logic statusSignExtendMode = 1'b0, statusSaturateMode = 1'b0, statusOverflowFlag = 1'b0;
   logic ready, dataWriteValid, moveNextValid, testFlag, overflowFlag, accZero, branchValid;
   logic signExtendMode, saturateMode, sign_extend_mode, saturate_mode, ov, tf, tfKnown;
   dsparith_op_type opCode = OP_NOP;
   logic [4:0]  shiftConst = 5'h0;
   logic [3:0]  dAddr = 4'h0, cAddr = 4'h0;
   logic [12:0] immOperand = 13'h0;
   logic [1:0]  statusProductShiftSel = 2'h0, productShiftSel, pm;
   logic [15:0] dataReadBus, programReadBus, multOperand, dataWriteBus, branchTarget, trg;
   logic [31:0] accumulator, productValue, acc, prg;
   logic [35:0] notes [$];
   int          bad_count = 0, num_checks = 0, cycles = 0;
   dsparith_datapath dut (.*);
   dsparith_mem_model mem (.clock(clock), .readEn(opValid), .dataAddr(dAddr), .coefAddr(cAddr),
      .moveNext(moveNextValid), .dataWord(dataReadBus), .coefWord(programReadBus));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 8000) begin
         bad_count++;
         stop_test();
      end
   end
   function automatic logic [31:0] seen(input logic [3:0] s);
      case (s)
         4'h0: seen = accumulator;
         4'h1: seen = productValue;
         4'h2: seen = {16'h0, dataWriteBus};
         4'h3: seen = {16'h0, branchTarget};
         // Test flag stays masked until an operation first gives it a value.
         default: seen = {6'h0, productShiftSel, signExtendMode, saturateMode, dataWriteValid,
            moveNextValid, branchValid, testFlag, overflowFlag, accZero, multOperand}
            & ~{13'h0, s == 4'h5, 18'h0};
      endcase
   endfunction
   task automatic check(input logic [3:0] s, input logic [31:0] e, input logic [31:0] g);
      string nm;
      case (s)
         4'h0: nm = "accumulator";
         4'h1: nm = "product";
         4'h2: nm = "store word";
         4'h3: nm = "branch target";
         default: nm = "flag word";
      endcase
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   always @(posedge clock) begin : watch
      logic took;
      logic [35:0] n;
      took = opValid === 1'b1 && ready === 1'b1;
      #2;
      while (took && notes.size() > 0) begin
         n = notes.pop_front();
         check(n[35:32], n[31:0], seen(n[35:32]));
      end
   end
   task automatic op(input dsparith_op_type c, input logic [4:0] sh);
      logic [15:0] d, k;
      logic [31:0] b, r;
      logic ad, sb, wv, mv, bv;
      @(negedge clock);
      opCode = c;
      shiftConst = sh;
      dAddr = 4'($urandom);
      cAddr = 4'($urandom);
      immOperand = 13'($urandom);
      opValid = 1'b1;
      if (ready !== 1'b1) return;
      d = mem.dataMem[dAddr];
      k = mem.coefMem[cAddr];
      b = c inside {[OP_LOAD_ACC:OP_SUB_ACC_REG_SHIFT]} ? ish(d, c inside {[OP_LOAD_ACC_REG_SHIFT:
         OP_SUB_ACC_REG_SHIFT]} ? {1'b0, trg[3:0]} : (sh > 5'h10 ? 5'h10 : sh), sign_extend_mode)
         : psh(prg, pm);
      ad = c inside {OP_ADD_ACC, OP_ADD_ACC_REG_SHIFT, OP_LOAD_OPERAND_ADD_PROD,
         OP_LOAD_OPERAND_ADD_MOVE, [OP_MULTIPLY_ACCUMULATE:OP_SQUARE_ADD], OP_ADD_PRODUCT};
      sb = c inside {OP_SUB_ACC, OP_SUB_ACC_REG_SHIFT, OP_LOAD_OPERAND_SUB_PROD, OP_SQUARE_SUBTRACT};
      r = ad ? acc + b : sb ? acc - b : acc;
      if (c inside {OP_LOAD_ACC, OP_LOAD_ACC_REG_SHIFT, OP_LOAD_OPERAND_MOVE_PROD}) r = b;
      if (c == OP_AND_ACC) r = acc & b;
      if (c == OP_OR_ACC) r = acc | b;
      if (c == OP_XOR_ACC) r = acc ^ b;
      if ((ad || sb) && acc[31] == (b[31] ^ sb) && r[31] != acc[31]) begin
         ov = 1'b1;
         if (saturate_mode) r = acc[31] ? SAT_NEGATIVE : SAT_POSITIVE;
      end
      if (c == OP_NORMALISE_ACC) begin
         tf = acc[31] ^ acc[30];
         if (!tf && acc != 32'h0) r = acc << 1;
      end
      if (c == OP_BIT_TEST_INDEXED) tf = d[4'hf - trg[3:0]];
      tfKnown |= c inside {OP_NORMALISE_ACC, OP_BIT_TEST_INDEXED};
      case (c)
         OP_SIGNED_MULTIPLY: prg = sx(trg) * sx(d);
         OP_SIGNED_MULTIPLY_IMM: prg = sx(trg) * {{19{immOperand[12]}}, immOperand};
         OP_UNSIGNED_MULTIPLY: prg = {16'h0, trg} * {16'h0, d};
         OP_MULTIPLY_ACCUMULATE, OP_MULTIPLY_ACC_MOVE: prg = sx(d) * sx(k);
         OP_SQUARE_ADD, OP_SQUARE_SUBTRACT: prg = sx(d) * sx(d);
         OP_LOAD_PRODUCT_HIGH: prg[31:16] = d;
         default: ;
      endcase
      if (c inside {[OP_LOAD_OPERAND:OP_LOAD_OPERAND_ADD_MOVE],
         [OP_MULTIPLY_ACCUMULATE:OP_SQUARE_SUBTRACT]}) trg = d;
      wv = c inside {OP_STORE_PRODUCT_HIGH, OP_STORE_PRODUCT_LOW};
      mv = c inside {OP_LOAD_OPERAND_ADD_MOVE, OP_MULTIPLY_ACC_MOVE};
      bv = c == OP_BRANCH_TO_ACC;
      if (wv) notes.push_back({4'h2, 16'h0, c == OP_STORE_PRODUCT_HIGH ? b[31:16] : b[15:0]});
      if (bv) notes.push_back({4'h3, 16'h0, acc[15:0]});
      acc = r;
      notes.push_back({4'h0, acc});
      if (c != OP_SIGNED_MULTIPLY_IMM) notes.push_back({4'h1, prg});
      notes.push_back({tfKnown ? 4'h4 : 4'h5, 6'h0, pm, sign_extend_mode, saturate_mode, wv, mv, bv, tf, ov,
         acc == 32'h0, trg});
   endtask
   task automatic ctl(input logic ld, input logic [4:0] v);
      @(negedge clock);
      opValid = 1'b0;
      statusLoad = ld;
      overflowBranchTaken = !ld;
      {statusProductShiftSel, statusSignExtendMode, statusSaturateMode, statusOverflowFlag} = v;
      if (ld) {pm, sign_extend_mode, saturate_mode, ov} = v;
      else ov = 1'b0;
      @(negedge clock);
      statusLoad = 1'b0;
      overflowBranchTaken = 1'b0;
   endtask
   initial begin
      void'($urandom(19));
      for (int i = 0; i < 16; i++) begin
         mem.dataMem[i] = 16'($urandom);
         mem.coefMem[i] = 16'($urandom);
      end
      {acc, prg, trg, pm, sign_extend_mode, saturate_mode, ov, tf, tfKnown} = {82'h0, 1'b1, 4'h0};
      repeat (6) @(posedge clock);
      @(negedge clock);
      srst = 1'b0;
      while (ready !== 1'b1) @(negedge clock);
      op(OP_NOP, 5'h0);
      for (int m = 0; m < 4; m++) begin
         ctl(1'b1, {2'(m), 1'(m), 1'(m >> 1), 1'b0});
         for (int c = 0; c < 29; c++) op(dsparith_op_type'(5'(c)), 5'(c % 18));
      end
      repeat (800) begin
         if ($urandom % 8 == 0) ctl(1'($urandom), 5'($urandom));
         else op(dsparith_op_type'(5'($urandom % 29)), 5'($urandom % 18));
      end
      @(negedge clock);
      opValid = 1'b0;
      repeat (3) @(negedge clock);
      stop_test();
   end
endmodule // dsparith_datapath_bench
bind dsparith_datapath dsparith_checker chk (.*);
`default_nettype wire
